/* File: hdl/fic_map.svh */
// Offsets, field positions, reset values and timing counts of the fault and interrupt capture block
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH

// Register byte offsets
`define FIC_OFS_FAULT      4'h0
`define FIC_OFS_IRQ_STAT   4'h4
`define FIC_OFS_IRQ_MASK   4'h8
`define FIC_OFS_CONFIG     4'hc

// Fault register bit positions
`define FIC_FB_PROT_OWN    0
`define FIC_FB_PROT_OTHER  1
`define FIC_FB_PARITY      2
`define FIC_FB_ADDR_MEM    5
`define FIC_FB_SYS0        7
`define FIC_FB_ADDR_IO     8
`define FIC_FB_SYS1_A      13
`define FIC_FB_SYS1_B      15

// Config fields
`define FIC_CFG_LEVEL_MODE 0
`define FIC_CFG_WIDTH      1

// Interrupt status bits
`define FIC_IS_POWER       0
`define FIC_IS_USER_LO     1
`define FIC_IS_IOL_LO      7
`define FIC_IS_FAULT       9
`define FIC_IS_CONSOLE     10
`define FIC_IS_WIDTH       11

// Reset values
`define FIC_RST_FAULT      16'h0000
`define FIC_RST_MASK       11'h000
`define FIC_RST_CONFIG     1'h0

// Timing
`define FIC_CLK_HZ         20000000
`define FIC_TIMER_HZ       100000
`define FIC_SYNC_STAGES    2

`endif

/* File: hdl/fic_pkg.sv */
// Types of the fault and interrupt capture block
package fic_pkg;

	typedef enum logic [1:0] {
		FIC_BUS_IDLE = 2'b00,
		FIC_BUS_REQ  = 2'b01,
		FIC_BUS_OWN  = 2'b10
	} fic_bus_state_t;

	typedef struct packed {
		logic       power_loss_irq;
		logic [5:0] user_irq;
		logic [1:0] io_level_irq;
		logic       console_request_n;
		logic       protect_violation_n;
		logic       parity_fail_n;
		logic       address_fault_n;
		logic [1:0] system_fault_edge;
		logic       cycle_active_n;
		logic       bus_grant_n;
		logic       bus_lock_n;
		logic       timer_clk;
	} fic_pins_t;

	typedef struct packed {
		fic_pins_t      pins_prev;
		logic [15:0]    fault_reg;
		logic [10:0]    irq_stat_reg;
		logic [10:0]    irq_mask_reg;
		logic           level_mode_reg;
		logic           console_pending_reg;
		logic           cycle_own_reg;
		logic           cycle_io_reg;
		fic_bus_state_t bus_state_reg;
		logic           timer_tick_reg;
		logic           ack_reg;
		logic [31:0]    rdata_reg;
	} fic_state_t;

endpackage

/* File: hdl/fic_sync.sv */
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module fic_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;

	// Synchronous reset only; reset value is a tie-off constant at the instance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= rst_val_i;
			sync_o   <= rst_val_i;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule

`default_nettype wire

/* File: hdl/fic_top.sv */
// Fault and interrupt capture block with Wishbone register access
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fic_map.svh"

// Overview of operation
// - Timer clock is synchronised, its rising edge gives one tick for timers A and B
// - Low reset pin initialises faults, status, config, console and bus state, but not the interrupt mask
// - Console request waits for instruction end, then enters console operations
// - Power-down interrupt is never masked or disabled
// - Power-down and user interrupts are edge or level per config mode bit
// - Two I/O level interrupts are active-high level requests
// - Protect error latches to bit 0 in own cycles, bit 1 otherwise
// - Parity error latches into fault bit 2 at cycle end
// - Address error latches to bit 8 in own I/O cycles, bit 5 otherwise
// - System fault 0 rising sets bit 7; fault 1 rising sets 13 and 15
// - Bus request asserted; bus taken only on grant with lock line high
// - Protect, parity and address faults sampled at the low-to-high edge of cycle-active
// - Cycle-active watched in foreign cycles too, faults still latched
module fic_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        reset_n_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// External pins
	input  wire logic        timer_clk_i,
	input  wire logic        console_request_n_i,
	input  wire logic        power_loss_irq_i,
	input  wire logic [5:0]  user_irq_i,
	input  wire logic [1:0]  io_level_irq_i,
	input  wire logic        protect_violation_n_i,
	input  wire logic        parity_fail_n_i,
	input  wire logic        address_fault_n_i,
	input  wire logic [1:0]  system_fault_edge_i,
	input  wire logic        cycle_active_n_i,
	input  wire logic        bus_grant_n_i,
	input  wire logic        bus_lock_n_i,
	// Core side
	input  wire logic        core_bus_need_i,
	input  wire logic        core_cycle_io_i,
	input  wire logic        core_cycle_done_i,
	input  wire logic        instr_done_i,
	output logic             timer_tick_o,
	output logic             console_enter_o,
	output logic             bus_request_n_o,
	output logic             bus_owned_o,
	output logic             reset_core_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers

	fic_pkg::fic_pins_t pins_raw;
	fic_pkg::fic_pins_t pins_idle;
	fic_pkg::fic_pins_t pins;
	logic               reset_n_sync;

	always_comb begin
		pins_raw.power_loss_irq      = power_loss_irq_i;
		pins_raw.user_irq            = user_irq_i;
		pins_raw.io_level_irq        = io_level_irq_i;
		pins_raw.console_request_n   = console_request_n_i;
		pins_raw.protect_violation_n = protect_violation_n_i;
		pins_raw.parity_fail_n       = parity_fail_n_i;
		pins_raw.address_fault_n     = address_fault_n_i;
		pins_raw.system_fault_edge   = system_fault_edge_i;
		pins_raw.cycle_active_n      = cycle_active_n_i;
		pins_raw.bus_grant_n         = bus_grant_n_i;
		pins_raw.bus_lock_n          = bus_lock_n_i;
		pins_raw.timer_clk           = timer_clk_i;
		// Inactive levels so no false edge appears after reset
		pins_idle                     = '0;
		pins_idle.console_request_n   = 1'b1;
		pins_idle.protect_violation_n = 1'b1;
		pins_idle.parity_fail_n       = 1'b1;
		pins_idle.address_fault_n     = 1'b1;
		pins_idle.cycle_active_n      = 1'b1;
		pins_idle.bus_grant_n         = 1'b1;
		pins_idle.bus_lock_n          = 1'b1;
	end

	fic_sync #(
		.WIDTH ($bits(fic_pkg::fic_pins_t) + 1)
	) u_sync (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.async_i   ({pins_raw, reset_n_i}),
		.rst_val_i ({pins_idle, 1'b0}),
		.sync_o    ({pins, reset_n_sync})
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	fic_pkg::fic_state_t st_reg;
	fic_pkg::fic_state_t st_next;

	logic        soft_reset;
	logic        cycle_end;
	logic [5:0]  user_hit;
	logic        power_hit;
	logic [10:0] irq_events;
	logic [15:0] fault_set;
	logic        wb_req;
	logic        wb_rd_stat;
	logic [31:0] rd_mux;

	always_comb begin
		st_next    = st_reg;
		soft_reset = ~reset_n_sync;
		wb_req     = wb_cyc_i & wb_stb_i & ~st_reg.ack_reg;
		wb_rd_stat = wb_req & ~wb_we_i & (wb_adr_i == `FIC_OFS_IRQ_STAT);

		st_next.pins_prev = pins;

		// Timer tick on synchronised rising edge
		st_next.timer_tick_reg = pins.timer_clk & ~st_reg.pins_prev.timer_clk;

		// Cycle end: low-to-high of cycle-active, own or foreign
		cycle_end = pins.cycle_active_n & ~st_reg.pins_prev.cycle_active_n;

		fault_set = '0;
		if (cycle_end) begin
			if (!pins.protect_violation_n) begin
				if (st_reg.cycle_own_reg) begin
					fault_set[`FIC_FB_PROT_OWN] = 1'b1;
				end else begin
					fault_set[`FIC_FB_PROT_OTHER] = 1'b1;
				end
			end
			fault_set[`FIC_FB_PARITY] = ~pins.parity_fail_n;
			if (!pins.address_fault_n) begin
				if (st_reg.cycle_own_reg && st_reg.cycle_io_reg) begin
					fault_set[`FIC_FB_ADDR_IO] = 1'b1;
				end else begin
					fault_set[`FIC_FB_ADDR_MEM] = 1'b1;
				end
			end
		end
		if (pins.system_fault_edge[0] & ~st_reg.pins_prev.system_fault_edge[0]) begin
			fault_set[`FIC_FB_SYS0] = 1'b1;
		end
		if (pins.system_fault_edge[1] & ~st_reg.pins_prev.system_fault_edge[1]) begin
			fault_set[`FIC_FB_SYS1_A] = 1'b1;
			fault_set[`FIC_FB_SYS1_B] = 1'b1;
		end

		// Edge or level sensing per mode bit
		if (st_reg.level_mode_reg) begin
			power_hit = pins.power_loss_irq;
			user_hit  = pins.user_irq;
		end else begin
			power_hit = pins.power_loss_irq & ~st_reg.pins_prev.power_loss_irq;
			user_hit  = pins.user_irq & ~st_reg.pins_prev.user_irq;
		end

		irq_events                  = '0;
		irq_events[`FIC_IS_POWER]   = power_hit;
		irq_events[`FIC_IS_USER_LO +: 6] = user_hit;
		irq_events[`FIC_IS_IOL_LO +: 2]  = pins.io_level_irq;
		irq_events[`FIC_IS_FAULT]   = |fault_set;
		irq_events[`FIC_IS_CONSOLE] = ~pins.console_request_n;

		// Sticky: set wins over the read-clear
		if (wb_rd_stat) begin
			st_next.irq_stat_reg = irq_events;
		end else begin
			st_next.irq_stat_reg = st_reg.irq_stat_reg | irq_events;
		end

		// Fault bits: set wins over a write-one-to-clear
		st_next.fault_reg = st_reg.fault_reg;
		if (wb_req && wb_we_i && wb_adr_i == `FIC_OFS_FAULT) begin
			if (wb_sel_i[0]) begin
				st_next.fault_reg[7:0] = st_reg.fault_reg[7:0] & ~wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				st_next.fault_reg[15:8] = st_reg.fault_reg[15:8] & ~wb_dat_i[15:8];
			end
		end
		st_next.fault_reg = st_next.fault_reg | fault_set;

		// Console request held until the running instruction ends
		if (!pins.console_request_n) begin
			st_next.console_pending_reg = 1'b1;
		end
		if (st_reg.console_pending_reg && instr_done_i) begin
			st_next.console_pending_reg = 1'b0;
		end

		// Bus acquisition
		case (st_reg.bus_state_reg)
			fic_pkg::FIC_BUS_IDLE: begin
				if (core_bus_need_i) begin
					st_next.bus_state_reg = fic_pkg::FIC_BUS_REQ;
				end
			end
			fic_pkg::FIC_BUS_REQ: begin
				if (!pins.bus_grant_n && pins.bus_lock_n) begin
					st_next.bus_state_reg = fic_pkg::FIC_BUS_OWN;
					st_next.cycle_own_reg = 1'b1;
					st_next.cycle_io_reg  = core_cycle_io_i;
				end
			end
			fic_pkg::FIC_BUS_OWN: begin
				if (core_cycle_done_i) begin
					st_next.bus_state_reg = fic_pkg::FIC_BUS_IDLE;
				end
			end
			default: begin
				st_next.bus_state_reg = fic_pkg::FIC_BUS_IDLE;
			end
		endcase
		// Ownership tag lives until a cycle end is sampled outside the OWN state
		if (cycle_end && st_reg.bus_state_reg != fic_pkg::FIC_BUS_OWN) begin
			st_next.cycle_own_reg = 1'b0;
			st_next.cycle_io_reg  = 1'b0;
		end

		// Register writes
		if (wb_req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `FIC_OFS_CONFIG) begin
				st_next.level_mode_reg = wb_dat_i[`FIC_CFG_LEVEL_MODE];
			end
			if (wb_adr_i == `FIC_OFS_IRQ_MASK) begin
				st_next.irq_mask_reg[7:0] = wb_dat_i[7:0];
			end
		end
		if (wb_req && wb_we_i && wb_sel_i[1] && wb_adr_i == `FIC_OFS_IRQ_MASK) begin
			st_next.irq_mask_reg[10:8] = wb_dat_i[10:8];
		end
		// Power-down bit of the mask is hardwired open
		st_next.irq_mask_reg[`FIC_IS_POWER] = 1'b1;

		// Read mux; unmapped offsets read zero and still ack
		case (wb_adr_i)
			`FIC_OFS_FAULT:    rd_mux = {16'h0000, st_reg.fault_reg};
			`FIC_OFS_IRQ_STAT: rd_mux = {21'h000000, st_reg.irq_stat_reg};
			`FIC_OFS_IRQ_MASK: rd_mux = {21'h000000, st_reg.irq_mask_reg};
			`FIC_OFS_CONFIG:   rd_mux = {31'h00000000, st_reg.level_mode_reg};
			default:           rd_mux = 32'h00000000;
		endcase
		st_next.ack_reg   = wb_req;
		st_next.rdata_reg = wb_req ? rd_mux : st_reg.rdata_reg;

		if (soft_reset) begin
			st_next.fault_reg           = `FIC_RST_FAULT;
			st_next.irq_stat_reg        = '0;
			st_next.level_mode_reg      = `FIC_RST_CONFIG;
			st_next.console_pending_reg = 1'b0;
			st_next.bus_state_reg       = fic_pkg::FIC_BUS_IDLE;
			st_next.cycle_own_reg       = 1'b0;
			st_next.cycle_io_reg        = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg                     <= '0;
			st_reg.pins_prev           <= '1;
			st_reg.pins_prev.power_loss_irq    <= 1'b0;
			st_reg.pins_prev.user_irq          <= 6'h00;
			st_reg.pins_prev.io_level_irq      <= 2'h0;
			st_reg.pins_prev.system_fault_edge <= 2'h0;
			st_reg.pins_prev.timer_clk         <= 1'b0;
			st_reg.fault_reg           <= `FIC_RST_FAULT;
			st_reg.irq_mask_reg        <= `FIC_RST_MASK | 11'h001;
			st_reg.level_mode_reg      <= `FIC_RST_CONFIG;
			st_reg.bus_state_reg       <= fic_pkg::FIC_BUS_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_dat_o        = st_reg.rdata_reg;
	assign wb_ack_o        = st_reg.ack_reg;
	assign timer_tick_o    = st_reg.timer_tick_reg;
	assign console_enter_o = st_reg.console_pending_reg & instr_done_i;
	assign bus_request_n_o = ~(st_reg.bus_state_reg == fic_pkg::FIC_BUS_REQ);
	assign bus_owned_o     = st_reg.bus_state_reg == fic_pkg::FIC_BUS_OWN;
	assign reset_core_o    = ~reset_n_sync;
	assign irq_o           = |(st_reg.irq_stat_reg & st_reg.irq_mask_reg);

endmodule

`default_nettype wire

/* File: bench/fic_properties.sv */
// Port-level assertions for the fault and interrupt capture block
`timescale 1ns/1ps
`default_nettype none
module fic_checker (
	// Clock and resets
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        reset_n_i,
	// Register bus
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Pins and core side
	input wire logic        timer_clk_i,
	input wire logic        power_loss_irq_i,
	input wire logic        bus_lock_n_i,
	input wire logic        instr_done_i,
	input wire logic        timer_tick_o,
	input wire logic        console_enter_o,
	input wire logic        bus_request_n_o,
	input wire logic        bus_owned_o,
	input wire logic        reset_core_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_tick_follows: assert property ($rose(timer_clk_i) |-> ##[1:6] timer_tick_o)
		else $error("no tick after timer clock edge");
	a_tick_single: assert property (timer_tick_o |=> !timer_tick_o)
		else $error("tick wider than one cycle");
	a_reset_low: assert property ((!reset_n_i) [*3] |-> reset_core_o)
		else $error("core not held in reset");
	a_reset_high: assert property (reset_n_i [*3] |-> !reset_core_o)
		else $error("core reset stuck");
	a_console_gate: assert property (console_enter_o |-> instr_done_i)
		else $error("console entry before instruction end");
	a_power_unmasked: assert property ($rose(power_loss_irq_i) && reset_n_i |-> ##[1:6] irq_o)
		else $error("power-down request not raised");
	a_mask_bit0: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h8 |-> wb_dat_o[0])
		else $error("power-down mask bit cleared");
	a_take_unlocked: assert property ((!bus_lock_n_i) [*4] |=> !$rose(bus_owned_o))
		else $error("bus taken while locked");
	a_take_after_req: assert property ($rose(bus_owned_o) |-> $past(bus_request_n_o) == 1'b0)
		else $error("bus taken without request");
endmodule
bind fic_top fic_checker i_fic_checker (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.timer_clk_i(timer_clk_i), .power_loss_irq_i(power_loss_irq_i), .bus_lock_n_i(bus_lock_n_i),
	.instr_done_i(instr_done_i), .timer_tick_o(timer_tick_o), .console_enter_o(console_enter_o),
	.bus_request_n_o(bus_request_n_o), .bus_owned_o(bus_owned_o), .reset_core_o(reset_core_o),
	.irq_o(irq_o));
`default_nettype wire

/* File: bench/fic_arbiter.sv */
// Model of the external bus arbiter and the locking master
`timescale 1ns/1ps
`default_nettype none
module fic_arbiter (
	// Clock
	input  wire logic clk_i,
	// Request and scenario controls
	input  wire logic bus_request_n_i,
	input  wire logic hold_lock_i,
	input  wire logic slow_i,
	// Arbiter lines
	output var logic  bus_grant_n_o,
	output logic      bus_lock_n_o
);
	int wait_cnt = 0;
	initial bus_grant_n_o = 1'b1;
	// Another master locks the bus while told to
	assign bus_lock_n_o = ~hold_lock_i;
	always @(posedge clk_i) begin
		if (bus_request_n_i) begin
			wait_cnt <= 0;
			bus_grant_n_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= (slow_i ? 6 : 1))
				bus_grant_n_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: bench/fic_tb.sv */
// Self-checking bench for the fault and interrupt capture block
`timescale 1ns/1ps
`default_nettype none
`include "fic_map.svh"
module testbench;
	logic clk_i = 1'b0, rst_i = 1'b1, rstn = 1'b1, cyc = 1'b0, we = 1'b0, tclk = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, gnt_n, lock_n, tick, enter, req_n, owned, core_rst, irq;
	logic con_n = 1'b1, pwr = 1'b0, prot_n = 1'b1, par_n = 1'b1, adrf_n = 1'b1, act_n = 1'b1;
	logic [5:0] usr = 6'h00;
	logic [1:0] iol = 2'h0, sysf = 2'h0;
	logic need = 1'b0, io = 1'b0, done = 1'b0, instr = 1'b0, hold = 1'b0, slow = 1'b0;
	logic [7:0] tdiv = 8'h00;
	int ticks = 0, t0, bad_count = 0, checks = 0;
	fic_top i_fic_top (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(rstn), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .timer_clk_i(tclk), .console_request_n_i(con_n),
		.power_loss_irq_i(pwr), .user_irq_i(usr), .io_level_irq_i(iol),
		.protect_violation_n_i(prot_n), .parity_fail_n_i(par_n), .address_fault_n_i(adrf_n),
		.system_fault_edge_i(sysf), .cycle_active_n_i(act_n), .bus_grant_n_i(gnt_n),
		.bus_lock_n_i(lock_n), .core_bus_need_i(need), .core_cycle_io_i(io),
		.core_cycle_done_i(done), .instr_done_i(instr), .timer_tick_o(tick),
		.console_enter_o(enter), .bus_request_n_o(req_n), .bus_owned_o(owned),
		.reset_core_o(core_rst), .irq_o(irq));
	fic_arbiter i_fic_arbiter (.clk_i(clk_i), .bus_request_n_i(req_n), .hold_lock_i(hold),
		.slow_i(slow), .bus_grant_n_o(gnt_n), .bus_lock_n_o(lock_n));
	// 20 MHz, far above the timer sampling minimum
	initial forever #25 clk_i = ~clk_i;
	// Timer clock of 100 kHz: toggles every 100 cycles
	always @(posedge clk_i) begin
		tdiv <= (tdiv == 8'h63) ? 8'h00 : tdiv + 8'h01;
		if (tdiv == 8'h63)
			tclk <= ~tclk;
		if (tick === 1'b1)
			ticks <= ticks + 1;
	end
	//////////////////////////////////////////////////////////////////////////////
	task tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Request held until the edge that samples ack high; data taken there
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		if (ack !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: no bus acknowledge", $time);
		end
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Bus cycle with fault levels held across its trailing edge
	task flt(input logic p, input logic r, input logic a);
		tk(1);
		act_n <= 1'b0;
		prot_n <= p;
		par_n <= r;
		adrf_n <= a;
		tk(4);
		act_n <= 1'b1;
		tk(3);
		prot_n <= 1'b1;
		par_n <= 1'b1;
		adrf_n <= 1'b1;
		tk(6);
	endtask
	task test_done;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		tk(10);
		rst_i <= 1'b0;
		rd(`FIC_OFS_FAULT, 32'h0);
		rd(`FIC_OFS_IRQ_MASK, 32'h1);
		rd(`FIC_OFS_CONFIG, 32'h0);
		rd(4'h2, 32'h0);
		usr <= 6'h01;
		tk(8);
		@(negedge clk_i);
		chk(irq, 1'b0);
		rd(`FIC_OFS_IRQ_STAT, 32'h2);
		pwr <= 1'b1;
		usr <= 6'h3f;
		iol <= 2'h3;
		tk(8);
		@(negedge clk_i);
		chk(irq, 1'b1);
		rd(`FIC_OFS_IRQ_STAT, 32'h1fd);
		rd(`FIC_OFS_IRQ_STAT, 32'h180);
		wb(1'b1, `FIC_OFS_CONFIG, 32'h1);
		tk(8);
		rd(`FIC_OFS_IRQ_STAT, 32'h1ff);
		pwr <= 1'b0;
		usr <= 6'h00;
		iol <= 2'h0;
		wb(1'b1, `FIC_OFS_CONFIG, 32'h0);
		tk(8);
		wb(1'b0, `FIC_OFS_IRQ_STAT, 32'h0);
		rd(`FIC_OFS_IRQ_STAT, 32'h0);
		@(negedge clk_i);
		chk(irq, 1'b0);
		flt(1'b0, 1'b0, 1'b0);
		rd(`FIC_OFS_FAULT, 32'h26);
		wb(1'b1, `FIC_OFS_FAULT, 32'hffff);
		rd(`FIC_OFS_FAULT, 32'h0);
		// Locked and slow grant first, then a prompt I/O acquisition
		for (int k = 0; k < 2; k++) begin
			hold <= (k == 0);
			slow <= (k == 0);
			io <= k[0];
			need <= 1'b1;
			tk(14);
			@(negedge clk_i);
			chk(owned, k[0]);
			tk(1);
			hold <= 1'b0;
			repeat (40) if (owned !== 1'b1) @(posedge clk_i);
			need <= 1'b0;
			flt(1'b0, 1'b1, 1'b0);
			done <= 1'b1;
			tk(1);
			done <= 1'b0;
		end
		rd(`FIC_OFS_FAULT, 32'h121);
		sysf <= 2'h3;
		tk(4);
		sysf <= 2'h0;
		tk(6);
		rd(`FIC_OFS_FAULT, 32'ha1a1);
		rstn <= 1'b0;
		tk(4);
		@(negedge clk_i);
		chk(core_rst, 1'b1);
		tk(1);
		rstn <= 1'b1;
		tk(4);
		rd(`FIC_OFS_FAULT, 32'h0);
		con_n <= 1'b0;
		tk(6);
		@(negedge clk_i);
		chk(enter, 1'b0);
		tk(1);
		instr <= 1'b1;
		@(negedge clk_i);
		chk(enter, 1'b1);
		tk(1);
		instr <= 1'b0;
		con_n <= 1'b1;
		t0 = ticks;
		tk(400);
		chk(ticks - t0, 2);
		test_done;
	end
	initial begin
		tk(20000);
		bad_count++;
		test_done;
	end
endmodule
`default_nettype wire
